// [inc/irh_consts.svh]
`ifndef IRH_CONSTS_SVH
`define IRH_CONSTS_SVH

// Register byte offsets
`define IRH_ACK_OFS 12'h000
`define IRH_SP_OFS 12'h004
`define IRH_STAT_OFS 12'h008
`define IRH_MASK_OFS 12'h00C
`define IRH_ICR_BASE 12'h040
`define IRH_ICR_STEP 12'h004

// Control register fields
`define IRH_LVL_LSB 0
`define IRH_LVL_MSB 2
`define IRH_REQ_BIT 3
`define IRH_POL_BIT 4

// Reset values
`define IRH_SP_RESET 16'h0000
`define IRH_LVL_RESET 3'h0
`define IRH_MASK_RESET 3'h0

// Status event bits
`define IRH_EV_SWACK 0
`define IRH_EV_NMI 1
`define IRH_EV_POLCHG 2
`define IRH_EV_W 3

// Source layout
`define IRH_EXT_NUM 6

`endif

// [inc/irh_pkg.sv]
package irh_pkg;
  typedef logic [2:0] irh_level_t;
  typedef logic [15:0] irh_sp_t;
  typedef logic [2:0] irh_events_t;
endpackage

// [src/irh_top.sv]
`timescale 1ns/1ps
`include "irh_consts.svh"
// How it works
// - Core acknowledge takes source number and level, then clears it.
// - Software read of acknowledge word clears the winning request bit too.
// - Reset loads the stack pointer register with zero.
// - Non-maskable input is always passed on; nothing can block it.
// - Polarity change can set an external request; software clears it after.
// - A request arriving during a control write is kept, not lost.
module irh_top #(
  parameter int NSRC = 16
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [5:0] EXT_IRQ_INPUTS,
  input wire logic NMI_N,
  input wire logic [NSRC-1:0] PERIPH_REQ,
  input wire logic CORE_ACK,
  input wire logic CORE_NMI_ACK,
  output logic INT_REQ,
  output logic [7:0] INT_NUM,
  output logic [2:0] INT_LEVEL,
  output logic NMI_REQ,
  output logic [15:0] STACK_PTR,
  output logic IRQ
);

  localparam int IW = $clog2(NSRC);

  // Refuse source counts the decode cannot serve
  if (NSRC < 7 || NSRC > 64) begin : g_bad
    $error("NSRC must lie between 7 and 64");
  end

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Highest level wins, lower number breaks ties
  function automatic logic [IW+2:0] pick(input logic [NSRC-1:0] r,
                                         input logic [3*NSRC-1:0] l);
    logic [2:0] best;
    logic [IW-1:0] idx;
    best = 3'h0;
    idx = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (r[i] && l[3*i +: 3] > best) begin
        best = l[3*i +: 3];
        idx = IW'(i);
      end
    end
    return {best, idx};
  endfunction

  // Byte offset of a source control register
  function automatic logic [11:0] icr_ofs(input int i);
    return 12'(`IRH_ICR_BASE + `IRH_ICR_STEP * 12'(i));
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [5:0] ext_s1;
  logic [5:0] ext_s2;
  logic [5:0] ext_eff_d;
  logic nmi_s1;
  logic nmi_s2;
  logic nmi_d;

  // Two flops before any logic looks at pins
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      ext_s1 <= 6'h00;
      ext_s2 <= 6'h00;
      nmi_s1 <= 1'b1;
      nmi_s2 <= 1'b1;
    end else begin
      ext_s1 <= EXT_IRQ_INPUTS;
      ext_s2 <= ext_s1;
      nmi_s1 <= NMI_N;
      nmi_s2 <= nmi_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus address phase

  logic [NSRC-1:0] req;
  logic [3*NSRC-1:0] lvl;
  logic [5:0] pol;
  logic wr_pend;
  logic [11:0] wr_addr;
  logic [2:0] evt;
  logic [2:0] mask;
  irh_pkg::irh_sp_t sp;

  logic addr_ok;
  logic rd_go;
  logic [IW+2:0] win;
  logic [5:0] ext_eff;
  logic [NSRC-1:0] set_req;
  logic [NSRC-1:0] clr_req;
  logic [NSRC-1:0] keep_req;
  logic [NSRC-1:0] next_req;
  logic [2:0] set_evt;
  logic [IW+2:0] next_win;

  assign addr_ok = HSEL && HTRANS[1] && HREADY;
  assign rd_go = addr_ok && !HWRITE;
  assign win = pick(req, lvl);
  assign ext_eff = ext_s2 ^ pol;
  assign next_win = pick(next_req, lvl);

  // Latch write address for the data phase
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
    end else begin
      wr_pend <= addr_ok && HWRITE;
      wr_addr <= HADDR[11:0];
    end
  end

  // Zero-wait slave, always OKAY
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  // Read data, captured in the address phase
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      HRDATA <= 32'h00000000;
    end else if (rd_go) begin
      HRDATA <= 32'h00000000;
      if (HADDR[11:0] == `IRH_ACK_OFS) begin
        HRDATA <= {21'h000000, win[IW+2:IW], 8'(win[IW-1:0])};
      end
      if (HADDR[11:0] == `IRH_SP_OFS) begin
        HRDATA <= {16'h0000, sp};
      end
      if (HADDR[11:0] == `IRH_STAT_OFS) begin
        HRDATA <= {29'h00000000, evt};
      end
      if (HADDR[11:0] == `IRH_MASK_OFS) begin
        HRDATA <= {29'h00000000, mask};
      end
      for (int i = 0; i < NSRC; i++) begin
        if (HADDR[11:0] == icr_ofs(i)) begin
          HRDATA[`IRH_LVL_MSB:`IRH_LVL_LSB] <= lvl[3*i +: 3];
          HRDATA[`IRH_REQ_BIT] <= req[i];
        end
      end
      // Polarity only on the external sources
      for (int i = 0; i < `IRH_EXT_NUM; i++) begin
        if (HADDR[11:0] == icr_ofs(i)) begin
          HRDATA[`IRH_POL_BIT] <= pol[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Request bits

  // Event detection and clear sources
  always_comb begin
    set_req = PERIPH_REQ;
    clr_req = '0;
    keep_req = '1;
    set_evt = 3'h0;
    for (int i = 0; i < `IRH_EXT_NUM; i++) begin
      set_req[i] = PERIPH_REQ[i] || (ext_eff[i] && !ext_eff_d[i]);
    end
    // Acknowledge by core or by software read
    if ((CORE_ACK || (rd_go && HADDR[11:0] == `IRH_ACK_OFS))
        && win[IW+2:IW] != 3'h0) begin
      clr_req[win[IW-1:0]] = 1'b1;
    end
    if (rd_go && HADDR[11:0] == `IRH_ACK_OFS && win[IW+2:IW] != 3'h0) begin
      set_evt[`IRH_EV_SWACK] = 1'b1;
    end
    if (!nmi_s2 && nmi_d) begin
      set_evt[`IRH_EV_NMI] = 1'b1;
    end
    for (int i = 0; i < NSRC; i++) begin
      if (wr_pend && wr_addr == icr_ofs(i)) begin
        keep_req[i] = HWDATA[`IRH_REQ_BIT];
      end
    end
    for (int i = 0; i < `IRH_EXT_NUM; i++) begin
      if (wr_pend && wr_addr == icr_ofs(i)
          && HWDATA[`IRH_POL_BIT] != pol[i]) begin
        set_evt[`IRH_EV_POLCHG] = 1'b1;
      end
    end
    // New request beats any clear in the same cycle
    next_req = ((req & keep_req) & ~clr_req) | set_req;
  end

  // Request bit storage
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      req <= '0;
      ext_eff_d <= 6'h00;
    end else begin
      req <= next_req;
      ext_eff_d <= ext_eff;
    end
  end

  // Level and polarity fields
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      lvl <= '0;
      pol <= 6'h00;
    end else begin
      for (int i = 0; i < NSRC; i++) begin
        if (wr_pend && wr_addr == icr_ofs(i)) begin
          lvl[3*i +: 3] <= HWDATA[`IRH_LVL_MSB:`IRH_LVL_LSB];
        end
      end
      for (int i = 0; i < `IRH_EXT_NUM; i++) begin
        if (wr_pend && wr_addr == icr_ofs(i)) begin
          pol[i] <= HWDATA[`IRH_POL_BIT];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stack pointer

  // Reset value, then software owned
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      sp <= `IRH_SP_RESET;
    end else if (wr_pend && wr_addr == `IRH_SP_OFS) begin
      sp <= HWDATA[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Core side outputs

  // Winner presented to the core each cycle
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      INT_REQ <= 1'b0;
      INT_NUM <= 8'h00;
      INT_LEVEL <= `IRH_LVL_RESET;
      STACK_PTR <= `IRH_SP_RESET;
    end else begin
      INT_REQ <= next_win[IW+2:IW] != 3'h0;
      INT_NUM <= 8'(next_win[IW-1:0]);
      INT_LEVEL <= next_win[IW+2:IW];
      STACK_PTR <= (wr_pend && wr_addr == `IRH_SP_OFS) ? HWDATA[15:0] : sp;
    end
  end

  // Non-maskable request, no enable can gate it
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      nmi_d <= 1'b1;
      NMI_REQ <= 1'b0;
    end else begin
      nmi_d <= nmi_s2;
      if (!nmi_s2 && nmi_d) begin
        NMI_REQ <= 1'b1;
      end else if (CORE_NMI_ACK) begin
        NMI_REQ <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Event status and interrupt line

  // Sticky events, write one to clear, set wins
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      evt <= 3'h0;
      mask <= `IRH_MASK_RESET;
    end else begin
      if (wr_pend && wr_addr == `IRH_STAT_OFS) begin
        evt <= (evt & ~HWDATA[2:0]) | set_evt;
      end else begin
        evt <= evt | set_evt;
      end
      if (wr_pend && wr_addr == `IRH_MASK_OFS) begin
        mask <= HWDATA[2:0];
      end
    end
  end

  // Level interrupt from unmasked events
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |((evt | set_evt) & mask);
    end
  end

endmodule

// [bench/irh_top_props.sv]
`timescale 1ns/1ps
module irh_top_props #(
  parameter int NSRC = 16
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADYOUT,
  input wire logic [31:0] HRDATA,
  input wire logic HRESP,
  input wire logic NMI_N,
  input wire logic [NSRC-1:0] PERIPH_REQ,
  input wire logic CORE_ACK,
  input wire logic CORE_NMI_ACK,
  input wire logic INT_REQ,
  input wire logic [7:0] INT_NUM,
  input wire logic [2:0] INT_LEVEL,
  input wire logic NMI_REQ,
  input wire logic [15:0] STACK_PTR
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  ////////////////////////////////////////////////////////////////////////////
  property p_sp_rst;
    $fell(RESET) |-> STACK_PTR == 16'h0000 && !INT_REQ && !NMI_REQ;
  endproperty
  a_sp_rst: assert property (p_sp_rst)
    else $error("outputs not cleared by reset");
  property p_nmi_set;
    $fell(NMI_N) |-> ##[1:6] NMI_REQ;
  endproperty
  a_nmi_set: assert property (p_nmi_set)
    else $error("nmi fall not latched");
  property p_nmi_hold;
    NMI_REQ && !CORE_NMI_ACK |=> NMI_REQ;
  endproperty
  a_nmi_hold: assert property (p_nmi_hold)
    else $error("nmi request dropped without ack");
  property p_nmi_clr;
    NMI_REQ && CORE_NMI_ACK && !(!$past(NMI_N, 2) && $past(NMI_N, 3))
      |=> !NMI_REQ;
  endproperty
  a_nmi_clr: assert property (p_nmi_clr)
    else $error("nmi request not cleared by ack");
  property p_lvl;
    INT_REQ |-> INT_LEVEL != 3'h0;
  endproperty
  a_lvl: assert property (p_lvl)
    else $error("request with level zero");
  property p_ack_clr;
    CORE_ACK && INT_REQ && INT_NUM >= 8'h06 && PERIPH_REQ == '0
      |=> !(INT_REQ && INT_NUM == $past(INT_NUM));
  endproperty
  a_ack_clr: assert property (p_ack_clr)
    else $error("acked request still pending");
  property p_ack_rd;
    HSEL && HTRANS[1] && !HWRITE && HADDR[11:0] == 12'h000 && INT_REQ
      && !CORE_ACK |=> HRDATA[10:0] == {$past(INT_LEVEL), $past(INT_NUM)};
  endproperty
  a_ack_rd: assert property (p_ack_rd)
    else $error("ack word read wrong");
  property p_rd_hold;
    !(HSEL && HTRANS[1] && !HWRITE) |=> $stable(HRDATA);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed without read");
  property p_okay;
    HREADYOUT && !HRESP;
  endproperty
  a_okay: assert property (p_okay)
    else $error("bus slave not ready or not okay");
endmodule
bind irh_top irh_top_props #(.NSRC(NSRC)) irh_top_props_i (.*);

// [bench/irh_core_model.sv]
`timescale 1ns/1ps
module irh_core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  input wire logic [3:0] wait_n,
  input wire logic int_req,
  input wire logic nmi_req,
  output logic core_ack,
  output logic core_nmi_ack
);
  logic [3:0] cnt;
  // Non-maskable ack, never gated
  always_ff @(posedge clk) begin
    if (rst) begin
      core_nmi_ack <= 1'b0;
    end else begin
      core_nmi_ack <= nmi_req && !core_nmi_ack;
    end
  end
  // Maskable ack after wait_n cycles, only while enabled
  always_ff @(posedge clk) begin
    if (rst || core_ack || !int_req || !en) begin
      core_ack <= 1'b0;
      cnt <= 4'h0;
    end else if (cnt >= wait_n) begin
      core_ack <= 1'b1;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

// [bench/irh_top_tb.sv]
`timescale 1ns/1ps
`include "irh_consts.svh"
module irh_top_tb;
  logic REF_CLK, RESET, HSEL, HWRITE, NMI_N, CORE_ACK, CORE_NMI_ACK, en;
  logic INT_REQ, NMI_REQ, IRQ, HREADYOUT, HRESP;
  logic [31:0] HADDR, HWDATA, HRDATA, q, rnd;
  logic [1:0] HTRANS;
  logic [5:0] EXT_IRQ_INPUTS;
  logic [15:0] PERIPH_REQ, STACK_PTR;
  logic [7:0] INT_NUM;
  logic [2:0] INT_LEVEL;
  logic [3:0] wait_n;
  logic [10:0] expq[$];
  int errors = 0, total_checks = 0, nmi_seen = 0, cyc = 0;
  irh_top irh_top_i (.HSIZE(3'h2), .HREADY(HREADYOUT), .*);
  irh_core_model irh_core_model_i (.clk(REF_CLK), .rst(RESET), .en(en),
    .wait_n(wait_n), .int_req(INT_REQ), .nmi_req(NMI_REQ),
    .core_ack(CORE_ACK), .core_nmi_ack(CORE_NMI_ACK));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // One single AHB transfer, then read data kept in q
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    HSEL <= 1'b1;
    HWRITE <= w;
    HADDR <= {20'h0, a};
    HTRANS <= 2'h2;
    do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
    q = HRDATA;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    REF_CLK = 1'b0;
    forever #4 REF_CLK = ~REF_CLK;
  end
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      close_out();
    end
  end
  // Result watcher against the noted acks
  always @(posedge REF_CLK) begin
    if (CORE_NMI_ACK === 1'b1) nmi_seen++;
    if (CORE_ACK === 1'b1 && INT_REQ === 1'b1)
      chk({21'h0, INT_LEVEL, INT_NUM},
        expq.size() ? {21'h0, expq.pop_front()} : 32'hFFFF);
  end
  // Main sequence
  initial begin
    {HSEL, HWRITE, HTRANS, HADDR, HWDATA, PERIPH_REQ, EXT_IRQ_INPUTS} = '0;
    {en, wait_n} = '0;
    RESET = 1'b1;
    NMI_N = 1'b1;
    rnd = 32'h487E;
    repeat (2) @(posedge REF_CLK);
    RESET <= 1'b0;
    @(posedge REF_CLK);
    chk(STACK_PTR, 32'h0);
    rd(`IRH_SP_OFS, 32'h0);
    rd(12'h100, 32'h0);
    rnd = lfsr(rnd);
    bus(1'b1, `IRH_SP_OFS, rnd & 32'hFFFF);
    rd(`IRH_SP_OFS, rnd & 32'hFFFF);
    chk(STACK_PTR, rnd & 32'hFFFF);
    $display("reset test done");
    bus(1'b1, 12'h05C, 32'h5);
    bus(1'b1, 12'h064, 32'h3);
    repeat (4) @(posedge REF_CLK);
    en <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      rnd = lfsr(rnd);
      wait_n <= k ? rnd[3:0] : 4'h0;
      expq.push_back(11'h507);
      expq.push_back(11'h309);
      PERIPH_REQ <= 16'h0280;
      @(posedge REF_CLK);
      PERIPH_REQ <= 16'h0;
      repeat (40) @(posedge REF_CLK);
      chk(expq.size(), 32'h0);
    end
    bus(1'b1, 12'h040, 32'h4);
    expq.push_back(11'h400);
    EXT_IRQ_INPUTS <= 6'h01;
    repeat (30) @(posedge REF_CLK);
    chk(expq.size(), 32'h0);
    $display("ack test done");
    en <= 1'b0;
    bus(1'b1, `IRH_MASK_OFS, 32'h1);
    bus(1'b1, 12'h060, 32'h2);
    PERIPH_REQ <= 16'h0100;
    @(posedge REF_CLK);
    PERIPH_REQ <= 16'h0;
    repeat (3) @(posedge REF_CLK);
    rd(`IRH_ACK_OFS, 32'h208);
    rd(`IRH_ACK_OFS, 32'h0);
    chk(IRQ, 32'h1);
    rd(`IRH_STAT_OFS, 32'h1);
    bus(1'b1, `IRH_STAT_OFS, 32'h7);
    repeat (2) @(posedge REF_CLK);
    chk(IRQ, 32'h0);
    $display("soft ack test done");
    bus(1'b1, `IRH_MASK_OFS, 32'h2);
    NMI_N <= 1'b0;
    repeat (10) @(posedge REF_CLK);
    NMI_N <= 1'b1;
    chk(nmi_seen, 32'h1);
    chk(IRQ, 32'h1);
    rd(`IRH_STAT_OFS, 32'h2);
    bus(1'b1, `IRH_STAT_OFS, 32'h7);
    $display("nmi test done");
    bus(1'b1, 12'h048, 32'h10);
    repeat (4) @(posedge REF_CLK);
    rd(12'h048, 32'h18);
    bus(1'b1, 12'h048, 32'h10);
    rd(12'h048, 32'h10);
    rd(`IRH_STAT_OFS, 32'h4);
    PERIPH_REQ <= 16'h0080;
    bus(1'b1, 12'h05C, 32'h5);
    PERIPH_REQ <= 16'h0;
    rd(12'h05C, 32'hD);
    $display("control write test done");
    RESET <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    RESET <= 1'b0;
    @(posedge REF_CLK);
    chk(STACK_PTR, 32'h0);
    rd(`IRH_SP_OFS, 32'h0);
    $display("mid reset test done");
    close_out();
  end
endmodule
